// ---- design/pip_pkg.sv ----
// Shared constants and types for the product information record parser
package pip_pkg;

  // ---------------------------------------------------------------
  // Item codes
  // ---------------------------------------------------------------
  localparam logic [6:0] PIP_ITEM_NAME  = 7'h02;
  localparam logic [6:0] PIP_ITEM_RO    = 7'h10;
  localparam logic [6:0] PIP_ITEM_RW    = 7'h11;
  localparam logic [3:0] PIP_SMALL_END  = 4'hF;
  localparam logic [7:0] PIP_NAME_TAG   = 8'h82;

  // Tag byte field positions
  localparam int PIP_LARGE_BIT   = 7;
  localparam int PIP_SCODE_HI    = 6;
  localparam int PIP_SCODE_LO    = 3;
  localparam int PIP_SLEN_HI     = 2;

  // ---------------------------------------------------------------
  // Keywords (first character, second character)
  // ---------------------------------------------------------------
  localparam logic [15:0] PIP_KW_CHECKSUM = 16'h5256;
  localparam logic [15:0] PIP_KW_EXTCAP   = 16'h4350;
  localparam logic [7:0]  PIP_KW_VENDOR0  = 8'h56;
  localparam logic [7:0]  PIP_CHAR_ZERO   = 8'h30;
  localparam logic [7:0]  PIP_CHAR_NINE   = 8'h39;
  localparam logic [7:0]  PIP_CHAR_UA     = 8'h41;
  localparam logic [7:0]  PIP_CHAR_UZ     = 8'h5A;

  // Capability data layout
  localparam logic [7:0]  PIP_CAP_LEN     = 8'h04;
  localparam logic [7:0]  PIP_BAR_MAX     = 8'h05;
  localparam logic [1:0]  PIP_CAP_IDX_ID  = 2'h0;
  localparam logic [1:0]  PIP_CAP_IDX_BAR = 2'h1;
  localparam logic [1:0]  PIP_CAP_IDX_OLO = 2'h2;
  localparam logic [1:0]  PIP_CAP_IDX_OHI = 2'h3;

  // Datapath sizes and reset values
  localparam int          PIP_BYTE_W      = 9;
  localparam int          PIP_FIFO_DEPTH  = 8;
  localparam logic [7:0]  PIP_SUM_RST     = 8'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PIP_EV_NAME = 2'h0,
    PIP_EV_HDR  = 2'h1,
    PIP_EV_DATA = 2'h2
  } pip_ev_e;

  typedef enum logic [10:0] {
    PIP_ST_IDLE  = 11'h001,
    PIP_ST_TAG   = 11'h002,
    PIP_ST_LEN0  = 11'h004,
    PIP_ST_LEN1  = 11'h008,
    PIP_ST_NAME  = 11'h010,
    PIP_ST_KW0   = 11'h020,
    PIP_ST_KW1   = 11'h040,
    PIP_ST_KWLEN = 11'h080,
    PIP_ST_KWDAT = 11'h100,
    PIP_ST_SKIP  = 11'h200,
    PIP_ST_DONE  = 11'h400
  } pip_state_e;

endpackage

// ---- design/pip_byte_if.sv ----
// Byte stream carrier with valid/ready between parser modules
`timescale 1ns/1ps
interface pip_byte_if;
  import pip_pkg::*;
  logic                  valid;
  logic                  ready;
  logic [PIP_BYTE_W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- design/pip_fifo.sv ----
// Parameterised valid/ready FIFO for the record byte stream
`timescale 1ns/1ps
module pip_fifo
  import pip_pkg::*;
#(
  parameter int WIDTH = PIP_BYTE_W,
  parameter int DEPTH = PIP_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Streams
  pip_byte_if.snk   fill,
  pip_byte_if.src   drain
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             ready_reg;
  logic             push;
  logic             pop;

  assign push        = fill.valid && ready_reg;
  assign pop         = drain.ready && (count_reg != '0);
  assign fill.ready  = ready_reg;
  assign drain.valid = (count_reg != '0);
  assign drain.data  = mem[rdPtr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_reg] <= fill.data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b1;
    end else begin
      if (push) begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
      end
      count_reg <= count_next;
      // Registered ready keeps the fill side free of drain-side paths
      ready_reg <= (count_next != (AW+1)'(DEPTH));
    end
  end

  full_refuse_a : assert property (@(posedge clk) disable iff (rst) // [R20]
    (count_reg == (AW+1)'(DEPTH)) |-> !fill.ready)
    else $error("fifo accepts while full");

  count_track_a : assert property (@(posedge clk) disable iff (rst) // [R20]
    (push && !pop) |=> (count_reg == $past(count_reg) + 1'b1))
    else $error("fifo count lost a push");

endmodule

// ---- design/pip_product_info_parser.sv ----
// Walker and checker for the tagged product information record
`timescale 1ns/1ps
// Function
// R1 - Each keyword field has header: two keyword bytes then one length byte.
// R2 - First keyword character in first header byte, second in next.
// R3 - Keyword data is ASCII unless that keyword says otherwise.
// R4 - Card-name string item 02h must be first; carries name characters.
// R5 - Large item 10h is read-only list, 11h read/write list.
// R6 - Small item 0Fh ends the record; walking stops there.
// R7 - Undefined tags and keywords are reserved and left unrecognised.
// R8 - Vendor keyword: fixed first char, second 0..Z, alphanumeric data.
// R9 - Extended capability keyword has exactly four data bytes: id, bar index.
// R10 - Bar index above 5 is flagged invalid.
// R11 - Last two capability bytes are register offset, low byte first.
// R12 - Checksum passes when byte sum from 0 through checksum byte is zero.
// R13 - Bytes after checksum are padding; keyword end ends read-only region.
// R14 - Read/write region is never part of the checksum.
// R15 - Read-only list lacking the checksum keyword is malformed.
// R16 - Large item: bit 7 set, code bits 6:0, two length bytes LSB first.
// R17 - Small item: bit 7 clear, code bits 6:3, length bits 2:0.
// R18 - Read-only bytes are never written.
// R19 - Sticky flags: checksum mismatch, missing end item, field overrun.
// R20 - Bytes consumed strictly in ascending order, one per handshake.
module pip_product_info_parser
  import pip_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Control
  input  wire logic        start,
  // Storage byte stream
  input  wire logic        inValid,
  input  wire logic [7:0]  inByte,
  input  wire logic        inLast,
  output logic             inReady,
  // Field event stream
  output logic             evValid,
  input  wire logic        evReady,
  output pip_ev_e          evKind,
  output logic [7:0]       evByte,
  output logic [15:0]      evKey,
  output logic [7:0]       evLen,
  output logic             evRw,
  output logic             evAscii,
  output logic             evVendor,
  output logic             evKnown,
  // Extended capability
  output logic             capValid,
  output logic [7:0]       capId,
  output logic [7:0]       capBar,
  output logic [15:0]      capOffset,
  output logic             capBad,
  // Status
  output logic             busy,
  output logic             done,
  output logic             chkOk,
  output logic             errChecksum,
  output logic             errNoEnd,
  output logic             errOverrun,
  output logic             errMalformed
);

  // ---------------------------------------------------------------
  // Input buffering
  // ---------------------------------------------------------------
  pip_byte_if fillIf ();
  pip_byte_if drainIf ();

  // Storage port is read-only; nothing here can write back [R18]
  assign fillIf.valid = inValid;
  assign fillIf.data  = {inLast, inByte};
  assign inReady      = fillIf.ready;

  pip_fifo #(
    .WIDTH (PIP_BYTE_W),
    .DEPTH (PIP_FIFO_DEPTH)
  ) byteFifo (
    .clk   (clk),
    .rst   (rst),
    .fill  (fillIf.snk),
    .drain (drainIf.src)
  );

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  pip_state_e  state_reg;
  pip_state_e  state_next;
  logic [7:0]  b;
  logic        bLast;
  logic        fire;
  logic        stall;
  logic [6:0]  code_reg;
  logic [7:0]  lenLo_reg;
  logic [15:0] listRem_reg;
  logic [15:0] listRem_next;
  logic [7:0]  fieldRem_reg;
  logic [7:0]  dataIdx_reg;
  logic [15:0] key_reg;
  logic [7:0]  kwLen_reg;
  logic        inRw_reg;
  logic        firstTag_reg;
  logic        seenChk_reg;
  logic        sumOn_reg;
  logic [7:0]  sum_reg;
  logic [7:0]  sumNext;
  logic        listEnds;
  logic        isChkKw;
  logic        isCapKw;
  logic        isChkByte;
  logic        roEndNoChk;
  logic        kwOverrun;

  // Keyword is known when defined (checksum or capability) or of vendor form
  function automatic logic kwKnown(input logic [15:0] k);
    logic vend;
    vend = (k[15:8] == PIP_KW_VENDOR0) &&
           (((k[7:0] >= PIP_CHAR_ZERO) && (k[7:0] <= PIP_CHAR_NINE)) ||
            ((k[7:0] >= PIP_CHAR_UA) && (k[7:0] <= PIP_CHAR_UZ)));
    return vend || (k == PIP_KW_CHECKSUM) || (k == PIP_KW_EXTCAP);
  endfunction

  assign b         = drainIf.data[7:0];
  assign bLast     = drainIf.data[8];
  assign stall     = evValid && !evReady;
  // One byte per handshake, in arrival order [R20]
  assign drainIf.ready = !(state_reg inside {PIP_ST_IDLE, PIP_ST_DONE}) && !stall;
  assign fire      = drainIf.valid && drainIf.ready;
  assign listEnds  = (listRem_reg == 16'h0001);
  assign listRem_next = listRem_reg - 16'h0001;
  assign isChkKw   = !inRw_reg && (key_reg == PIP_KW_CHECKSUM);
  assign isCapKw   = (key_reg == PIP_KW_EXTCAP);
  assign isChkByte = (state_reg == PIP_ST_KWDAT) && isChkKw && (dataIdx_reg == 8'h00) && !seenChk_reg;
  assign sumNext   = sum_reg + b;
  // Only the low byte can be exceeded by an 8-bit length
  assign kwOverrun = (state_reg == PIP_ST_KWLEN) && (listRem_next[15:8] == 8'h00) && (b > listRem_next[7:0]);
  assign roEndNoChk = fire && listEnds && !inRw_reg && !seenChk_reg && !isChkByte &&
                      (state_reg inside {PIP_ST_KW0, PIP_ST_KW1, PIP_ST_KWLEN, PIP_ST_KWDAT}) &&
                      (code_reg == PIP_ITEM_RO);

  // ---------------------------------------------------------------
  // Walk state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      PIP_ST_IDLE: begin
        if (start) state_next = PIP_ST_TAG;
      end
      PIP_ST_TAG: begin
        if (fire) begin
          if (b[PIP_LARGE_BIT]) begin // [R16]
            state_next = PIP_ST_LEN0;
          end else if (b[PIP_SCODE_HI:PIP_SCODE_LO] == PIP_SMALL_END) begin // [R6]
            state_next = PIP_ST_DONE;
          end else if (b[PIP_SLEN_HI:0] != 3'h0) begin // [R17]
            state_next = PIP_ST_SKIP;
          end
        end
      end
      PIP_ST_LEN0: begin
        if (fire) state_next = PIP_ST_LEN1;
      end
      PIP_ST_LEN1: begin
        if (fire) begin
          if ({b, lenLo_reg} == 16'h0000) begin
            state_next = PIP_ST_TAG;
          end else if (code_reg == PIP_ITEM_NAME) begin // [R4]
            state_next = PIP_ST_NAME;
          end else if (code_reg == PIP_ITEM_RO || code_reg == PIP_ITEM_RW) begin // [R5]
            state_next = PIP_ST_KW0;
          end else begin
            state_next = PIP_ST_SKIP; // [R7]
          end
        end
      end
      PIP_ST_NAME, PIP_ST_SKIP: begin
        if (fire && listEnds) state_next = PIP_ST_TAG;
      end
      PIP_ST_KW0: begin
        if (fire) state_next = listEnds ? PIP_ST_TAG : PIP_ST_KW1; // [R1]
      end
      PIP_ST_KW1: begin
        if (fire) state_next = listEnds ? PIP_ST_TAG : PIP_ST_KWLEN; // [R1]
      end
      PIP_ST_KWLEN: begin
        if (fire) begin
          if (listEnds) state_next = PIP_ST_TAG;
          else if (kwOverrun) state_next = PIP_ST_SKIP; // [R19]
          else if (b == 8'h00) state_next = PIP_ST_KW0;
          else state_next = PIP_ST_KWDAT;
        end
      end
      PIP_ST_KWDAT: begin
        if (fire && listEnds) state_next = PIP_ST_TAG;
        else if (fire && fieldRem_reg == 8'h01) state_next = PIP_ST_KW0;
      end
      PIP_ST_DONE: begin
        if (start) state_next = PIP_ST_TAG;
      end
    endcase
    // Store ran out before the end item
    if (fire && bLast && state_next != PIP_ST_DONE) state_next = PIP_ST_DONE;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) state_reg <= PIP_ST_IDLE;
    else     state_reg <= state_next;
  end

  // ---------------------------------------------------------------
  // Item and field counters
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_reg     <= '0;
      lenLo_reg    <= '0;
      listRem_reg  <= '0;
      fieldRem_reg <= '0;
      dataIdx_reg  <= '0;
      key_reg      <= '0;
      kwLen_reg    <= '0;
      inRw_reg     <= 1'b0;
    end else if (start && state_reg inside {PIP_ST_IDLE, PIP_ST_DONE}) begin
      // Stale list flag would mark the next record as read/write [R14]
      inRw_reg     <= 1'b0;
    end else if (fire) begin
      unique case (state_reg)
        PIP_ST_TAG: begin
          code_reg    <= b[PIP_LARGE_BIT] ? b[6:0] : {3'h0, b[PIP_SCODE_HI:PIP_SCODE_LO]};
          listRem_reg <= {13'h0000, b[PIP_SLEN_HI:0]}; // [R17]
        end
        PIP_ST_LEN0: lenLo_reg <= b;
        PIP_ST_LEN1: begin
          listRem_reg <= {b, lenLo_reg}; // [R16]
          inRw_reg    <= (code_reg == PIP_ITEM_RW);
        end
        PIP_ST_KW0: begin
          key_reg[15:8] <= b; // [R2]
          listRem_reg   <= listRem_next;
        end
        PIP_ST_KW1: begin
          key_reg[7:0]  <= b; // [R2]
          listRem_reg   <= listRem_next;
        end
        PIP_ST_KWLEN: begin
          kwLen_reg    <= b;
          fieldRem_reg <= b;
          dataIdx_reg  <= 8'h00;
          listRem_reg  <= listRem_next;
        end
        PIP_ST_KWDAT: begin
          fieldRem_reg <= fieldRem_reg - 8'h01;
          dataIdx_reg  <= dataIdx_reg + 8'h01;
          listRem_reg  <= listRem_next;
        end
        default: listRem_reg <= listRem_next;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checksum
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sum_reg     <= PIP_SUM_RST;
      sumOn_reg   <= 1'b0;
      seenChk_reg <= 1'b0;
    end else if (start && state_reg inside {PIP_ST_IDLE, PIP_ST_DONE}) begin
      sum_reg     <= PIP_SUM_RST;
      sumOn_reg   <= 1'b1;
      seenChk_reg <= 1'b0;
    end else if (fire && sumOn_reg) begin
      sum_reg <= sumNext; // [R12]
      // Summing stops at the checksum byte, so padding and the
      // read/write list never reach it [R13] [R14]
      if (isChkByte) begin
        sumOn_reg   <= 1'b0;
        seenChk_reg <= 1'b1;
      end
      // No checksum seen yet: still never sum into the read/write list
      if (state_reg == PIP_ST_LEN1 && code_reg == PIP_ITEM_RW) sumOn_reg <= 1'b0; // [R14]
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy         <= 1'b0;
      done         <= 1'b0;
      chkOk        <= 1'b0;
      errChecksum  <= 1'b0;
      errNoEnd     <= 1'b0;
      errOverrun   <= 1'b0;
      errMalformed <= 1'b0;
      firstTag_reg <= 1'b0;
    end else begin
      busy <= !(state_next inside {PIP_ST_IDLE, PIP_ST_DONE});
      done <= (state_next == PIP_ST_DONE);
      if (start && state_reg inside {PIP_ST_IDLE, PIP_ST_DONE}) begin
        chkOk        <= 1'b0;
        errChecksum  <= 1'b0;
        errNoEnd     <= 1'b0;
        errOverrun   <= 1'b0;
        errMalformed <= 1'b0;
        firstTag_reg <= 1'b1;
      end else if (fire) begin
        if (state_reg == PIP_ST_TAG) firstTag_reg <= 1'b0;
        if (state_reg == PIP_ST_TAG && firstTag_reg && b != PIP_NAME_TAG) errMalformed <= 1'b1; // [R4]
        if (roEndNoChk) errMalformed <= 1'b1; // [R15]
        if (isChkByte && sumOn_reg) begin
          if (sumNext == 8'h00) chkOk <= 1'b1; // [R12]
          else errChecksum <= 1'b1; // [R19]
        end
        if (kwOverrun && !listEnds) errOverrun <= 1'b1; // [R19]
        if ((state_reg inside {PIP_ST_KW0, PIP_ST_KW1}) && listEnds) errOverrun <= 1'b1; // [R19]
        if (state_reg == PIP_ST_KWDAT && listEnds && fieldRem_reg != 8'h01) errOverrun <= 1'b1; // [R19]
        if (bLast && state_next == PIP_ST_DONE && state_reg != PIP_ST_TAG) errNoEnd <= 1'b1; // [R19]
        if (bLast && state_reg == PIP_ST_TAG && !(!b[PIP_LARGE_BIT] &&
            b[PIP_SCODE_HI:PIP_SCODE_LO] == PIP_SMALL_END)) errNoEnd <= 1'b1; // [R19]
      end
    end
  end

  // ---------------------------------------------------------------
  // Field events
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evValid  <= 1'b0;
      evKind   <= PIP_EV_NAME;
      evByte   <= '0;
      evKey    <= '0;
      evLen    <= '0;
      evRw     <= 1'b0;
      evAscii  <= 1'b0;
      evVendor <= 1'b0;
      evKnown  <= 1'b0;
    end else begin
      if (evReady) evValid <= 1'b0;
      if (fire && (state_reg inside {PIP_ST_NAME, PIP_ST_KWLEN, PIP_ST_KWDAT})) begin
        evValid  <= !(state_reg == PIP_ST_KWLEN && kwOverrun);
        evByte   <= b;
        evKey    <= key_reg;
        evLen    <= (state_reg == PIP_ST_KWLEN) ? b : kwLen_reg;
        evRw     <= inRw_reg;
        evVendor <= (key_reg[15:8] == PIP_KW_VENDOR0) && kwKnown(key_reg); // [R8]
        evKnown  <= kwKnown(key_reg); // [R7]
        // Checksum and capability data are binary, the rest ASCII [R3]
        evAscii  <= (state_reg == PIP_ST_NAME) || !(isChkKw || isCapKw);
        unique case (state_reg)
          PIP_ST_NAME:  evKind <= PIP_EV_NAME;
          PIP_ST_KWLEN: evKind <= PIP_EV_HDR; // [R1]
          default:      evKind <= PIP_EV_DATA;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Extended capability capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      capValid  <= 1'b0;
      capId     <= '0;
      capBar    <= '0;
      capOffset <= '0;
      capBad    <= 1'b0;
    end else if (fire && state_reg == PIP_ST_KWDAT && isCapKw) begin
      unique case (dataIdx_reg[1:0])
        PIP_CAP_IDX_ID:  capId <= b; // [R9]
        PIP_CAP_IDX_BAR: capBar <= b; // [R9]
        PIP_CAP_IDX_OLO: capOffset[7:0] <= b; // [R11]
        PIP_CAP_IDX_OHI: capOffset[15:8] <= b; // [R11]
      endcase
      if (fieldRem_reg == 8'h01) begin
        capValid <= 1'b1;
        // Wrong length or bar index out of range [R9] [R10]
        capBad   <= (kwLen_reg != PIP_CAP_LEN) ||
                    ((dataIdx_reg == 8'h01) ? (b > PIP_BAR_MAX) : (capBar > PIP_BAR_MAX));
      end
    end else if (start && state_reg inside {PIP_ST_IDLE, PIP_ST_DONE}) begin
      capValid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  end_stop_a : assert property (@(posedge clk) disable iff (rst) // [R6]
    (fire && state_reg == PIP_ST_TAG && !b[7] && b[6:3] == PIP_SMALL_END) |=> done ##1 (done && !drainIf.ready))
    else $error("walk did not stop at end item");

  list_open_a : assert property (@(posedge clk) disable iff (rst) // [R5]
    (fire && state_reg == PIP_ST_LEN1 && code_reg == PIP_ITEM_RW && {b, lenLo_reg} != 16'h0000 && !bLast)
    |=> (state_reg == PIP_ST_KW0) && inRw_reg)
    else $error("read/write list not opened");

  sum_check_a : assert property (@(posedge clk) disable iff (rst) // [R12]
    (fire && isChkByte && sumOn_reg) |=> (chkOk == ($past(sumNext) == 8'h00)) && (errChecksum == !chkOk))
    else $error("checksum verdict wrong");

  rw_nosum_a : assert property (@(posedge clk) disable iff (rst) // [R14]
    (state_reg != PIP_ST_IDLE && inRw_reg) |-> !sumOn_reg)
    else $error("read/write bytes summed");

  bar_range_a : assert property (@(posedge clk) disable iff (rst) // [R10]
    $rose(capValid) && kwLen_reg == PIP_CAP_LEN |-> (capBad == (capBar > PIP_BAR_MAX)))
    else $error("bar index check wrong");

  key_order_a : assert property (@(posedge clk) disable iff (rst) // [R2]
    (fire && state_reg == PIP_ST_KW0 && !listEnds) ##1 (fire && state_reg == PIP_ST_KW1)
    |=> key_reg == {$past(b, 2), $past(b)})
    else $error("keyword characters swapped");

  missing_chk_a : assert property (@(posedge clk) disable iff (rst) // [R15]
    roEndNoChk |=> errMalformed)
    else $error("missing checksum not reported");

  overrun_flag_a : assert property (@(posedge clk) disable iff (rst) // [R19]
    (fire && kwOverrun && !listEnds) |=> errOverrun ##1 (state_reg inside {PIP_ST_SKIP, PIP_ST_TAG, PIP_ST_DONE}))
    else $error("overrun not flagged");

  stall_hold_a : assert property (@(posedge clk) disable iff (rst) // [R20]
    (evValid && !evReady) |-> !drainIf.ready)
    else $error("byte taken while event pending");

endmodule

// ---- testbench/pip_store_model.sv ----
// Behavioural storage component streaming record bytes
`timescale 1ns/1ps
module pip_store_model (
  // Stream
  input  wire logic       clk,
  input  wire logic       inReady,
  output logic            inValid,
  output logic [7:0]      inByte,
  output logic            inLast
);
  logic [7:0] mem[$];
  bit         slow;
  bit         hs;
  bit         gap;
  int         idx;

  task automatic load(input logic [7:0] q[$], input bit s);
    mem = q;
    slow = s;
    idx = 0;
  endtask

  initial begin
    inValid = 1'b0;
    inByte = 8'h00;
    inLast = 1'b0;
  end

  // Ascending addresses, one byte per handshake
  always @(posedge clk) begin
    hs = inValid && inReady;
    #1;
    gap = hs && slow;
    if (hs) idx++;
    if (idx < mem.size() && !gap) begin
      inValid = 1'b1;
      inByte = mem[idx];
      inLast = (idx == mem.size() - 1);
    end else begin
      // Released line never repeats the last value
      inValid = 1'b0;
      inByte = ~inByte;
      inLast = 1'b0;
    end
  end
endmodule

// ---- testbench/pip_product_info_parser_tb_top.sv ----
// Self-checking bench for the record parser
`timescale 1ns/1ps
module pip_product_info_parser_tb_top;
  import pip_pkg::*;
  logic clk, rst, start, evReady, slowEv, inValid, inLast, inReady, evValid, evRw, evAscii;
  logic evVendor, evKnown, capValid, capBad, busy, done, chkOk, errChecksum, errNoEnd, errOverrun, errMalformed;
  logic [7:0] inByte, capId, capBar, evByte, evLen;
  logic [15:0] evKey, capOffset;
  pip_ev_e evKind;
  logic [7:0] rec[$];
  logic [35:0] hdr[$];
  int err_count, n_tests, nEv;

  pip_product_info_parser DUT (.clk(clk), .rst(rst), .start(start), .inValid(inValid), .inByte(inByte),
    .inLast(inLast), .inReady(inReady), .evValid(evValid), .evReady(evReady), .evKind(evKind), .evByte(evByte),
    .evKey(evKey), .evLen(evLen), .evRw(evRw), .evAscii(evAscii), .evVendor(evVendor), .evKnown(evKnown),
    .capValid(capValid), .capId(capId), .capBar(capBar), .capOffset(capOffset), .capBad(capBad),
    .busy(busy), .done(done), .chkOk(chkOk), .errChecksum(errChecksum), .errNoEnd(errNoEnd),
    .errOverrun(errOverrun), .errMalformed(errMalformed));
  pip_store_model store (.clk(clk), .inReady(inReady), .inValid(inValid), .inByte(inByte), .inLast(inLast));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Consumer stalls every other cycle when asked
  always @(posedge clk) #1 evReady = slowEv ? ~evReady : 1'b1;
  always @(posedge clk) begin
    if (evValid === 1'b1 && evReady === 1'b1) begin
      nEv++;
      if (evKind === PIP_EV_HDR) hdr.push_back({evAscii, evByte, evLen, evRw, evVendor, evKnown, evKey});
    end
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Name, read-only list (unknown, capability, checksum), read/write vendor item, end item
  task automatic walk(input logic [7:0] bar, input bit bad, input bit noEnd, input bit slow);
    logic [7:0] s;
    rec = '{8'h82, 8'h02, 8'h00, 8'h41, 8'h42, 8'h90, 8'h0F, 8'h00, 8'h5A, 8'h5A, 8'h00, 8'h43, 8'h50,
            8'h04, 8'h07, bar, 8'h34, 8'h12, 8'h52, 8'h56, 8'h02};
    s = 8'h00;
    foreach (rec[i]) s += rec[i];
    rec.push_back(8'h00 - s + {7'h00, bad});
    rec = {rec, 8'h00, 8'h91, 8'h04, 8'h00, 8'h56, 8'h31, 8'h01, 8'h58};
    if (!noEnd) rec.push_back(8'h78);
    run(slow);
    chk(hdr.size(), 4);
    chk(nEv, 13);
    chk(hdr[0], {1'b1, 8'h00, 8'h00, 3'b000, 16'h5A5A});
    chk(hdr[1], {1'b0, 8'h04, 8'h04, 3'b001, PIP_KW_EXTCAP});
    chk(hdr[2], {1'b0, 8'h02, 8'h02, 3'b001, PIP_KW_CHECKSUM});
    chk(hdr[3], {1'b1, 8'h01, 8'h01, 3'b111, 16'h5631});
    chk({capValid, capId, capBar}, {1'b1, 8'h07, bar});
    chk(capOffset, 16'h1234);
    chk(capBad, bar > 8'h05);
    chk({chkOk, errChecksum}, {!bad, bad});
    chk({errNoEnd, errOverrun, errMalformed}, {noEnd, 2'b00});
  endtask

  task automatic run(input bit slow);
    hdr.delete();
    nEv = 0;
    slowEv = slow;
    store.load(rec, slow);
    @(posedge clk) #1 start = 1'b1;
    @(posedge clk) #1 start = 1'b0;
    repeat (600) begin
      @(posedge clk);
      if (done === 1'b1 && busy === 1'b0) break;
    end
    #2 chk(done, 1'b1);
  endtask

  task automatic good_record;
    walk(8'h05, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic bad_sum_and_index_slow;
    walk(8'h06, 1'b1, 1'b0, 1'b1);
  endtask

  task automatic missing_end;
    walk(8'h00, 1'b0, 1'b1, 1'b0);
  endtask

  // Read-only list without checksum keyword, then an overlong read/write field
  task automatic no_checksum_overrun;
    rec = '{8'h82, 8'h00, 8'h00, 8'h90, 8'h03, 8'h00, 8'h5A, 8'h5A, 8'h00, 8'h91, 8'h04, 8'h00, 8'h56, 8'h31,
            8'h05, 8'h41, 8'h78};
    run(1'b0);
    chk({errMalformed, errOverrun, errNoEnd, chkOk, errChecksum}, 5'b11000);
    chk(nEv, 1);
  endtask

  task automatic name_missing;
    rec = '{8'h90, 8'h00, 8'h00, 8'h78};
    run(1'b0);
    chk(errMalformed, 1'b1);
    chk(hdr.size(), 0);
  endtask

  initial begin
    #(3000 * 100);
    err_count++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    start = 1'b0;
    evReady = 1'b1;
    slowEv = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    good_record();
    bad_sum_and_index_slow();
    missing_end();
    no_checksum_overrun();
    name_missing();
    print_verdict();
  end
endmodule
